// ### flash_cmd_pkg.sv
// opcodes, field positions, reset values and timing for the flash command core
package flash_cmd_pkg;
  // opcodes
  localparam logic [7:0] OP_DIE_SEL  = 8'hc2;
  localparam logic [7:0] OP_DIE_RD   = 8'hf8;
  localparam logic [7:0] OP_WL_SET   = 8'h06;
  localparam logic [7:0] OP_WL_CLR   = 8'h04;
  localparam logic [7:0] OP_VOL_EN   = 8'h50;
  localparam logic [7:0] OP_SR1_RD   = 8'h05;
  localparam logic [7:0] OP_SR2_RD   = 8'h35;
  localparam logic [7:0] OP_SR3_RD   = 8'h15;
  localparam logic [7:0] OP_SR1_WR   = 8'h01;
  localparam logic [7:0] OP_SR2_WR   = 8'h31;
  localparam logic [7:0] OP_SR3_WR   = 8'h11;
  localparam logic [7:0] OP_EXT_RD   = 8'hc8;
  localparam logic [7:0] OP_EXT_UA   = 8'hc5;
  localparam logic [7:0] OP_EXT_CFG  = 8'h56;
  localparam logic [7:0] OP_READ3    = 8'h03;
  localparam logic [7:0] OP_READ4    = 8'h13;
  // reset values
  localparam logic [7:0]  DIE_RST    = 8'h00;
  localparam logic [7:0]  EXT_RST    = 8'h00;
  localparam logic [23:0] STATUS_RST = 24'h000000;
  // status bits that a status write never touches
  localparam logic [23:0] STATUS_FIXED = 24'h0c8703;
  // field positions
  localparam int BIT_WIP    = 0;
  localparam int BIT_WEL    = 1;
  localparam int EXT_UA_BIT = 0;
  localparam int EXT_CFG_LO = 2;
  localparam int EXT_CFG_HI = 5;
  // byte and bit counts
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] ADDR_BYTES3  = 3'h3;
  localparam logic [2:0] ADDR_BYTES4  = 3'h4;
  localparam logic [2:0] WSR_ONE      = 3'h1;
  localparam logic [2:0] WSR_TWO      = 3'h2;
  localparam logic [7:0] FILL_BYTE    = 8'hff;
  // timing: plain default for the self-timed status write
  localparam int CLK_PERIOD_NS        = 5;
  localparam int STATUS_WRITE_TIME_NS = 2000000;
  localparam int STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
  // command sequencer states
  typedef enum logic [2:0] {
    ST_OPC  = 3'h0,
    ST_DIE  = 3'h1,
    ST_ADDR = 3'h2,
    ST_OUT  = 3'h3,
    ST_WSR  = 3'h4,
    ST_WEXT = 3'h5,
    ST_DONE = 3'h6,
    ST_SKIP = 3'h7
  } cmd_state_t;
endpackage

// ### byte_fifo.sv
// small flip-flop fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];  // entries
  logic [PW-1:0]    wr_q, wr_d;     // write index
  logic [PW-1:0]    rd_q, rd_d;     // read index
  logic [CW-1:0]    cnt_q, cnt_d;   // fill level
  logic             push, pop;

  assign in_ready_o  = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer and level update
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush_i) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      if (pop) rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      cnt_d = cnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // one storage word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys_i) begin
      if (push && !flush_i && wr_q == PW'(i)) mem_q[i] <= in_data_i;
    end
  end
endmodule

// ### flash_cmd_core.sv
// serial command decoder of one die in a stacked serial nor flash
`timescale 1ns/1ps
module flash_cmd_core #(
  parameter logic [7:0] DIE_NUM             = 8'h00,
  parameter int         STATUS_WRITE_CYCLES = flash_cmd_pkg::STATUS_WRITE_CYCLES,
  parameter int         ADDR_W              = 32,
  parameter int         FIFO_DEPTH          = 4
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // serial pins
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   so_oe_o,
  // control and status
  input  wire logic              addr4_mode_i,
  input  wire logic              soft_reset_i,
  input  wire logic              array_busy_i,
  input  wire logic              array_done_i,
  output logic [7:0]             active_die_o,
  output logic                   write_latch_flag_o,
  output logic                   op_in_progress_flag_o,
  output logic                   write_allowed_o,
  output logic [23:0]            status_o,
  output logic                   upper_address_bit_o,
  output logic [3:0]             ext_config_bits_o,
  // array read port
  output logic                   array_req_o,
  output logic [ADDR_W-1:0]      array_addr_o,
  input  wire logic              array_valid_i,
  input  wire logic [7:0]        array_data_i,
  output logic                   array_ready_o
);
  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [2:0] sy1_q;  // first stage, read by sy2_q only
  logic [2:0] sy2_q;  // {si, cs_n, sclk}
  logic [1:0] del_q;  // delayed cs_n, sclk
  logic       sck_rise, sck_fall, cs_rise, cs_low, si_s;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sy1_q <= 3'h2;
      sy2_q <= 3'h2;
      del_q <= 2'h2;
    end else begin
      sy1_q <= {si_i, cs_n_i, sclk_i};
      sy2_q <= sy1_q;
      del_q <= sy2_q[1:0];
    end
  end

  assign sck_rise = sy2_q[0] && !del_q[0];
  assign sck_fall = !sy2_q[0] && del_q[0];
  assign cs_rise  = sy2_q[1] && !del_q[1];
  assign cs_low   = !sy2_q[1];
  assign si_s     = sy2_q[2];

  //////////////////////////////////////////////////////////////////////////
  // state
  flash_cmd_pkg::cmd_state_t state_q, state_d;
  logic [7:0]        cmd_q, cmd_d;        // current opcode
  logic [7:0]        in_sr_q, in_sr_d;    // input shifter
  logic [2:0]        bit_q, bit_d;        // bit within byte
  logic [2:0]        nb_q, nb_d;          // bytes after opcode
  logic [31:0]       addr_q, addr_d;      // address shifter
  logic [15:0]       wdat_q, wdat_d;      // status write data
  logic [7:0]        ob_q, ob_d;          // byte being shifted out
  logic [2:0]        oc_q, oc_d;          // output bit index
  logic              so_q, so_d;
  logic              oe_q, oe_d;
  logic [7:0]        die_q, die_d;        // active die number
  logic              wel_q, wel_d;        // write latch flag
  logic              vol_q, vol_d;        // volatile enable armed
  logic [23:0]       sr_q, sr_d;          // status storage
  logic [23:0]       pend_q, pend_d;      // value waiting for timed write
  logic              wbusy_q, wbusy_d;    // timed write running
  logic [31:0]       wcnt_q, wcnt_d;
  logic [7:0]        ext_q, ext_d;        // extended register
  logic              req_q, req_d;        // array read open
  logic [ADDR_W-1:0] ra_q, ra_d;          // array read address

  // combinational helpers
  logic [7:0]  in_byte;
  logic        byte_done, die_act, op_in_progress_flag, wsr_ok, wsr_go, wel_set, wel_clr;
  logic        four_b, wsr_last;
  logic [31:0] addr_nx;
  logic [23:0] view, wval;
  logic [7:0]  src, cur;
  logic [2:0]  need;
  logic        f_pop, f_valid, f_in_ready;
  logic [7:0]  f_data;

  assign in_byte   = {in_sr_q[6:0], si_s};
  assign byte_done = sck_rise && bit_q == flash_cmd_pkg::BIT_LAST;
  assign die_act   = (die_q == DIE_NUM);
  assign op_in_progress_flag       = wbusy_q || array_busy_i;
  assign wsr_last  = wbusy_q && wcnt_q == 32'(STATUS_WRITE_CYCLES - 1);
  assign addr_nx   = {addr_q[30:0], si_s};
  assign four_b    = addr4_mode_i || cmd_q == flash_cmd_pkg::OP_READ4;
  assign need      = four_b ? flash_cmd_pkg::ADDR_BYTES4 : flash_cmd_pkg::ADDR_BYTES3;

  // live status: bit 0 busy, bit 1 write latch
  always_comb begin
    view = sr_q;
    view[flash_cmd_pkg::BIT_WIP] = op_in_progress_flag;
    view[flash_cmd_pkg::BIT_WEL] = wel_q;
  end

  // status write legality and merged value
  always_comb begin
    wsr_ok = 1'b0;
    wval   = sr_q;
    unique case (cmd_q)
      flash_cmd_pkg::OP_SR1_WR: begin
        if (nb_q == flash_cmd_pkg::WSR_ONE) begin
          wsr_ok = 1'b1;
          wval[7:0] = wdat_q[7:0];
        end else if (nb_q == flash_cmd_pkg::WSR_TWO) begin
          // first byte in goes to register one, second to register two
          wsr_ok = 1'b1;
          wval[7:0]  = wdat_q[15:8];
          wval[15:8] = wdat_q[7:0];
        end
      end
      flash_cmd_pkg::OP_SR2_WR: begin
        wsr_ok = (nb_q == flash_cmd_pkg::WSR_ONE);
        wval[15:8] = wdat_q[7:0];
      end
      flash_cmd_pkg::OP_SR3_WR: begin
        wsr_ok = (nb_q == flash_cmd_pkg::WSR_ONE);
        wval[23:16] = wdat_q[7:0];
      end
      default: wsr_ok = 1'b0;
    endcase
    // fixed bits keep their stored value
    wval = (sr_q & flash_cmd_pkg::STATUS_FIXED) | (wval & ~flash_cmd_pkg::STATUS_FIXED);
  end

  // a status write counts only on a byte boundary, with latch or volatile enable
  assign wsr_go = cs_rise && state_q == flash_cmd_pkg::ST_WSR && bit_q == '0
                  && wsr_ok && (wel_q || vol_q);

  // source of the next outgoing byte
  always_comb begin
    f_pop = 1'b0;
    unique case (cmd_q)
      flash_cmd_pkg::OP_DIE_RD: src = die_q;
      flash_cmd_pkg::OP_SR1_RD: src = view[7:0];
      flash_cmd_pkg::OP_SR2_RD: src = view[15:8];
      flash_cmd_pkg::OP_SR3_RD: src = view[23:16];
      flash_cmd_pkg::OP_EXT_RD: src = ext_q;
      default: begin
        // array data; an empty fifo sends filler
        src   = f_valid ? f_data : flash_cmd_pkg::FILL_BYTE;
        f_pop = sck_fall && state_q == flash_cmd_pkg::ST_OUT && oc_q == flash_cmd_pkg::BIT_LAST
                && cs_low;
      end
    endcase
    cur = (oc_q == flash_cmd_pkg::BIT_LAST) ? src : ob_q;
  end

  // write latch: set wins over any clear in the same cycle
  assign wel_set = cs_rise && state_q == flash_cmd_pkg::ST_DONE
                   && cmd_q == flash_cmd_pkg::OP_WL_SET;
  assign wel_clr = (cs_rise && state_q == flash_cmd_pkg::ST_DONE
                    && cmd_q == flash_cmd_pkg::OP_WL_CLR && !op_in_progress_flag)
                   || wsr_last || array_done_i;

  //////////////////////////////////////////////////////////////////////////
  // command sequencer next state
  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    in_sr_d = in_sr_q;
    bit_d   = bit_q;
    nb_d    = nb_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    ob_d    = ob_q;
    oc_d    = oc_q;
    so_d    = so_q;
    die_d   = die_q;
    vol_d   = vol_q;
    ext_d   = ext_q;
    req_d   = req_q;
    ra_d    = ra_q;
    if (cs_rise) begin
      // frame end: drop partial work and rearm
      state_d = flash_cmd_pkg::ST_OPC;
      bit_d   = '0;
      nb_d    = '0;
      oc_d    = flash_cmd_pkg::BIT_LAST;
      req_d   = 1'b0;
      if (state_q == flash_cmd_pkg::ST_DONE && cmd_q == flash_cmd_pkg::OP_VOL_EN) vol_d = 1'b1;
      if (wsr_go) vol_d = 1'b0;
    end else if (cs_low) begin
      if (sck_rise) begin
        in_sr_d = in_byte;
        bit_d   = bit_q + 3'h1;
        unique case (state_q)
          flash_cmd_pkg::ST_OPC: begin
            if (byte_done) begin
              cmd_d = in_byte;
              nb_d  = '0;
              oc_d  = flash_cmd_pkg::BIT_LAST;
              if (!(in_byte == flash_cmd_pkg::OP_SR1_WR || in_byte == flash_cmd_pkg::OP_SR2_WR
                    || in_byte == flash_cmd_pkg::OP_SR3_WR)) vol_d = 1'b0;
              if (!die_act) begin
                state_d = (in_byte == flash_cmd_pkg::OP_DIE_SEL) ? flash_cmd_pkg::ST_DIE
                                                                 : flash_cmd_pkg::ST_SKIP;
              end else begin
                unique case (in_byte)
                  flash_cmd_pkg::OP_DIE_SEL: state_d = flash_cmd_pkg::ST_DIE;
                  flash_cmd_pkg::OP_DIE_RD, flash_cmd_pkg::OP_SR1_RD,
                  flash_cmd_pkg::OP_SR2_RD, flash_cmd_pkg::OP_SR3_RD,
                  flash_cmd_pkg::OP_EXT_RD: state_d = flash_cmd_pkg::ST_OUT;
                  flash_cmd_pkg::OP_WL_SET, flash_cmd_pkg::OP_WL_CLR,
                  flash_cmd_pkg::OP_VOL_EN: state_d = flash_cmd_pkg::ST_DONE;
                  flash_cmd_pkg::OP_SR1_WR, flash_cmd_pkg::OP_SR2_WR,
                  flash_cmd_pkg::OP_SR3_WR: state_d = flash_cmd_pkg::ST_WSR;
                  flash_cmd_pkg::OP_EXT_UA,
                  flash_cmd_pkg::OP_EXT_CFG: state_d = flash_cmd_pkg::ST_WEXT;
                  flash_cmd_pkg::OP_READ3, flash_cmd_pkg::OP_READ4:
                    state_d = op_in_progress_flag ? flash_cmd_pkg::ST_SKIP : flash_cmd_pkg::ST_ADDR;
                  default: state_d = flash_cmd_pkg::ST_SKIP;
                endcase
              end
            end
          end
          flash_cmd_pkg::ST_DIE: begin
            if (byte_done) begin
              die_d   = in_byte;
              state_d = flash_cmd_pkg::ST_SKIP;
            end
          end
          flash_cmd_pkg::ST_ADDR: begin
            addr_d = addr_nx;
            if (byte_done) begin
              nb_d = nb_q + 3'h1;
              if (nb_q + 3'h1 == need) begin
                // upper bit only extends three-byte addresses
                ra_d    = four_b ? ADDR_W'(addr_nx)
                                 : ADDR_W'({ext_q[flash_cmd_pkg::EXT_UA_BIT], addr_nx[23:0]});
                req_d   = 1'b1;
                state_d = flash_cmd_pkg::ST_OUT;
              end
            end
          end
          flash_cmd_pkg::ST_WSR: begin
            wdat_d = {wdat_q[14:0], si_s};
            if (byte_done && nb_q != flash_cmd_pkg::ADDR_BYTES3) nb_d = nb_q + 3'h1;
          end
          flash_cmd_pkg::ST_WEXT: begin
            if (byte_done) begin
              if (cmd_q == flash_cmd_pkg::OP_EXT_UA)
                ext_d[flash_cmd_pkg::EXT_UA_BIT] = in_byte[flash_cmd_pkg::EXT_UA_BIT];
              else
                ext_d[flash_cmd_pkg::EXT_CFG_HI:flash_cmd_pkg::EXT_CFG_LO] =
                  in_byte[flash_cmd_pkg::EXT_CFG_HI:flash_cmd_pkg::EXT_CFG_LO];
              state_d = flash_cmd_pkg::ST_SKIP;
            end
          end
          // extra bits spoil a lone opcode
          flash_cmd_pkg::ST_DONE: state_d = flash_cmd_pkg::ST_SKIP;
          flash_cmd_pkg::ST_OUT, flash_cmd_pkg::ST_SKIP: state_d = state_q;
        endcase
      end
      // output side changes on falling serial clock
      if (sck_fall && state_q == flash_cmd_pkg::ST_OUT) begin
        so_d = cur[oc_q];
        if (oc_q == flash_cmd_pkg::BIT_LAST) ob_d = src;
        oc_d = oc_q - 3'h1;
      end
    end
    // array address steps once per byte taken in
    if (req_q && array_valid_i && f_in_ready && !cs_rise) ra_d = ra_q + ADDR_W'(1);
    if (soft_reset_i) ext_d = flash_cmd_pkg::EXT_RST;
    oe_d = !cs_rise && state_d == flash_cmd_pkg::ST_OUT && die_act;
  end

  // status, write latch and timed write
  always_comb begin
    sr_d    = sr_q;
    pend_d  = pend_q;
    wbusy_d = wbusy_q;
    wcnt_d  = wcnt_q;
    wel_d   = wel_q;
    if (wbusy_q) begin
      wcnt_d = wcnt_q + 32'h1;
      if (wsr_last) begin
        sr_d    = pend_q;
        wbusy_d = 1'b0;
      end
    end
    if (wsr_go) begin
      if (vol_q) begin
        sr_d = wval;
      end else begin
        pend_d  = wval;
        wbusy_d = 1'b1;
        wcnt_d  = '0;
      end
    end
    if (wel_clr) wel_d = 1'b0;
    if (wel_set) wel_d = 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= flash_cmd_pkg::ST_OPC;
      cmd_q   <= '0;
      in_sr_q <= '0;
      bit_q   <= '0;
      nb_q    <= '0;
      addr_q  <= '0;
      wdat_q  <= '0;
      ob_q    <= '0;
      oc_q    <= flash_cmd_pkg::BIT_LAST;
      so_q    <= 1'b0;
      oe_q    <= 1'b0;
      die_q   <= flash_cmd_pkg::DIE_RST;
      wel_q   <= 1'b0;
      vol_q   <= 1'b0;
      sr_q    <= flash_cmd_pkg::STATUS_RST;
      pend_q  <= flash_cmd_pkg::STATUS_RST;
      wbusy_q <= 1'b0;
      wcnt_q  <= '0;
      ext_q   <= flash_cmd_pkg::EXT_RST;
      req_q   <= 1'b0;
      ra_q    <= '0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      in_sr_q <= in_sr_d;
      bit_q   <= bit_d;
      nb_q    <= nb_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      ob_q    <= ob_d;
      oc_q    <= oc_d;
      so_q    <= so_d;
      oe_q    <= oe_d;
      die_q   <= die_d;
      wel_q   <= wel_d;
      vol_q   <= vol_d;
      sr_q    <= sr_d;
      pend_q  <= pend_d;
      wbusy_q <= wbusy_d;
      wcnt_q  <= wcnt_d;
      ext_q   <= ext_d;
      req_q   <= req_d;
      ra_q    <= ra_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data buffer; a full buffer holds the array off
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .flush_i     (cs_rise || !req_q),
    .in_valid_i  (array_valid_i && req_q),
    .in_data_i   (array_data_i),
    .in_ready_o  (f_in_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_pop)
  );

  // outputs
  assign so_o                  = so_q;
  assign so_oe_o               = oe_q;
  assign active_die_o          = die_q;
  assign write_latch_flag_o    = wel_q;
  assign op_in_progress_flag_o = op_in_progress_flag;
  assign write_allowed_o       = wel_q && !op_in_progress_flag;
  assign status_o              = view;
  assign upper_address_bit_o   = ext_q[flash_cmd_pkg::EXT_UA_BIT];
  assign ext_config_bits_o     = ext_q[flash_cmd_pkg::EXT_CFG_HI:flash_cmd_pkg::EXT_CFG_LO];
  assign array_req_o           = req_q;
  assign array_addr_o          = ra_q;
  assign array_ready_o         = f_in_ready && req_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wsr_start;
    wsr_go && !vol_q;
  endsequence
  sequence s_busy_two;
    op_in_progress_flag_o ##1 op_in_progress_flag_o;
  endsequence

  chk_die_after_reset: assert property (disable iff (1'b0) !rst_n_i |=> active_die_o == 8'h00)
    else $error("die not zero after reset");
  chk_die_select_load: assert property (state_q == flash_cmd_pkg::ST_DIE && byte_done && cs_low
    |=> active_die_o == $past(in_byte))
    else $error("die select not taken");
  chk_wdis_while_busy: assert property (cs_rise && state_q == flash_cmd_pkg::ST_DONE
    && cmd_q == flash_cmd_pkg::OP_WL_CLR && op_in_progress_flag && !array_done_i && !wsr_last
    |=> wel_q == $past(wel_q))
    else $error("write disable acted while busy");
  chk_wsr_busy_start: assert property (s_wsr_start |=> s_busy_two)
    else $error("timed status write did not raise busy");
  chk_wsr_end_latch: assert property (wsr_last && !wel_set |=> !wel_q && !wbusy_q)
    else $error("latch or busy not cleared at end of write");
  chk_fixed_bits_hold: assert property (((sr_q ^ $past(sr_q)) & flash_cmd_pkg::STATUS_FIXED)
    == 24'h000000)
    else $error("fixed status bit changed");
  chk_read_reject_busy: assert property (state_q == flash_cmd_pkg::ST_OPC && byte_done && cs_low
    && die_act && op_in_progress_flag && (in_byte == flash_cmd_pkg::OP_READ3 || in_byte == flash_cmd_pkg::OP_READ4)
    |=> state_q == flash_cmd_pkg::ST_SKIP ##1 !array_req_o)
    else $error("read accepted while busy");
  chk_idle_die_quiet: assert property (!$past(die_act) |-> !so_oe_o)
    else $error("inactive die drives output");
  chk_frame_end_reset: assert property (cs_rise |=> state_q == flash_cmd_pkg::ST_OPC
    && bit_q == 3'h0 && !so_oe_o)
    else $error("partial command kept after select release");
endmodule

// ### spi_host_model.sv
// serial host model driving the command core pins in mode 0
`timescale 1ns/1ps
module spi_host_model (
  // clock and pins
  input  wire logic clk_sys_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  logic oe_seen; // output enable seen during the last frame
  initial begin
    sclk_o = 1'b0; // sclk idles low outside frames
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // one frame: low n bits of tx sent msb first, so sampled before each rise
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge clk_sys_i) cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (int i = n - 1; i >= 0; i--) begin
      si_o <= tx[i];
      repeat (8) @(posedge clk_sys_i);
      // an undriven line shows the opposite of the held output bit
      rx = {rx[62:0], so_oe_i ? so_i : ~so_i};
      oe_seen = oe_seen | so_oe_i;
      sclk_o <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // released line must not keep its last value
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// ### tb_top.sv
// self-checking bench for the flash command core
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, soft_reset_i = 1'b0;
  logic array_busy_i = 1'b0, array_valid_i = 1'b0, addr4_mode_i = 1'b0, array_done_i = 1'b0;
  logic sclk, cs_n, si, so, oe, req, wlf, busy, uab, wa, rdy;
  logic [7:0] die;
  logic [23:0] status;
  logic [3:0] cfg;
  logic [31:0] addr;
  logic [63:0] rx;
  int fails = 0, check_count = 0;
  // rows: 8-bit commands stored below 16'h0100, bit 8 of the answer asks a compare
  localparam logic [15:0] TX [13] = '{16'hf800, 16'h0500, 16'h0006, 16'h0500,
    16'h0004, 16'h0500, 16'hc501, 16'h563c, 16'hc800, 16'h0050, 16'h01ff, 16'h0500,
    16'h3500};
  localparam logic [8:0] EX [13] = '{9'h100, 9'h100, 9'h000, 9'h102, 9'h000,
    9'h100, 9'h000, 9'h000, 9'h13d, 9'h000, 9'h000, 9'h1fc, 9'h100};
  always #2.5 clk_sys_i = ~clk_sys_i;
  // array answers one cycle after the request, data made from the address
  always @(posedge clk_sys_i) array_valid_i <= req;
  spi_host_model host_i (.clk_sys_i, .so_i(so), .so_oe_i(oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .si_o(si));
  flash_cmd_core #(.STATUS_WRITE_CYCLES(2000)) flash_cmd_core_i (
    .clk_sys_i, .rst_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_o(oe), .addr4_mode_i, .soft_reset_i, .array_busy_i,
    .array_done_i, .active_die_o(die), .write_latch_flag_o(wlf),
    .op_in_progress_flag_o(busy), .write_allowed_o(wa), .status_o(status),
    .upper_address_bit_o(uab), .ext_config_bits_o(cfg), .array_req_o(req),
    .array_addr_o(addr), .array_valid_i, .array_data_i(addr[7:0] ^ 8'h5a),
    .array_ready_o(rdy));
  task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("die", 0, die);
    chk("status", 0, status);
    chk("ready", 0, rdy);
    for (int i = 0; i < 13; i++) begin
      host_i.frame(TX[i], (TX[i][15:8] == 8'h00) ? 8 : 16, rx);
      if (EX[i][8]) chk("row", EX[i][7:0], rx[7:0]);
    end
    // two partial opcodes; kept bits would join into a latch set
    host_i.frame(64'h0, 4, rx);
    host_i.frame(64'h6, 4, rx);
    chk("latch", 0, wlf);
    host_i.frame(64'h03000010_0000, 48, rx);
    chk("read", 24'h4a4b, rx[15:0]);
    chk("upper", 8'h01, addr[31:24]);
    host_i.frame(64'h13_00000020_00, 48, rx);
    chk("read4", 24'h7a, rx[7:0]);
    chk("upper", 8'h00, addr[31:24]);
    // four-byte mode on a plain read: upper bit must still be ignored
    addr4_mode_i <= 1'b1;
    host_i.frame(64'h03_00000030_00, 48, rx);
    chk("read4m", 24'h6a, rx[7:0]);
    chk("upper", 8'h00, addr[31:24]);
    addr4_mode_i <= 1'b0;
    host_i.frame(16'hc201, 16, rx);
    chk("die", 8'h01, die);
    host_i.frame(16'hf800, 16, rx);
    chk("oe", 0, host_i.oe_seen);
    array_busy_i <= 1'b1;
    host_i.frame(16'hc200, 16, rx);
    chk("die", 0, die);
    host_i.frame(64'h03000000_00, 40, rx);
    chk("oe", 0, host_i.oe_seen);
    array_busy_i <= 1'b0;
    host_i.frame(16'h0006, 8, rx);
    chk("allowed", 1, wa);
    host_i.frame(16'h01a4, 16, rx);
    chk("busy", 1, busy);
    chk("allowed", 0, wa);
    host_i.frame(16'h0004, 8, rx);
    chk("latch", 1, wlf);
    for (int k = 0; k < 3000 && busy; k++) @(posedge clk_sys_i);
    if (busy !== 1'b0) begin
      fails++;
      final_report();
    end
    chk("status", 24'h0000a4, status);
    host_i.frame(16'h01ff, 16, rx);
    chk("busy", 0, busy);
    // volatile two-byte write: first byte to register one
    host_i.frame(16'h0050, 8, rx);
    host_i.frame(64'h0158c3, 24, rx);
    chk("status", 24'h004058, status);
    // status write cut four bits past a byte: dropped, latch kept
    host_i.frame(16'h0006, 8, rx);
    host_i.frame(64'h01a55, 20, rx);
    chk("busy", 0, busy);
    chk("status", 24'h00405a, status);
    // finished program in the array clears the latch
    array_done_i <= 1'b1;
    @(posedge clk_sys_i) array_done_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("latch", 0, wlf);
    soft_reset_i <= 1'b1;
    @(posedge clk_sys_i) soft_reset_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("ext", 0, {uab, cfg});
    final_report();
  end
endmodule
